//--- src/dci_cfg.svh
// constants of the drive communication slave: register addresses, field
// positions, reset values, limits and timing counts.
// assumes a 40 MHz core clock and 16-bit register words.
`ifndef DCI_CFG_SVH
`define DCI_CFG_SVH

// register addresses as seen by the serial host
`define DCI_RIN_ADDR 16'h2600
`define DCI_ROUT_ADDR 16'h2640
`define DCI_DLY_ADDR 16'h0909
`define DCI_FREQ_ADDR 16'h090A
`define DCI_SLOT_BASE 16'h090B
`define DCI_MAP_ADDR 16'h091E
`define DCI_NODE_ADDR 16'h0924
`define DCI_RATE_ADDR 16'h0925
`define DCI_WARN_ADDR 16'h0927
`define DCI_PROF_ADDR 16'h0928
`define DCI_STATE_ADDR 16'h0929

// control windows and their word offsets
`define DCI_WIN_LEGACY 16'h2000
`define DCI_WIN_PROFILE 16'h6000
`define DCI_WIN_CMD 8'h00
`define DCI_WIN_FREQ 8'h01
`define DCI_CAN_IDX_M1 16'h2020
`define DCI_CAN_IDX_M2 16'h2060
`define DCI_CAN_SUB_FIRST 8'h01

// function codes and exception codes
`define DCI_FN_READ 8'h03
`define DCI_FN_WRITE 8'h06
`define DCI_FN_ERR 8'h80
`define DCI_EXC_NONE 8'h00
`define DCI_EXC_FUNC 8'h01
`define DCI_EXC_ADDR 8'h02
`define DCI_EXC_DATA 8'h03
`define DCI_EXC_EXEC 8'h04

// field positions and widths
`define DCI_RIN_W 6
`define DCI_ROUT_W 4
`define DCI_WARN_MASK 16'h007B

// reset values and upper limits (delay in 0.1 ms, frequency in 0.01 Hz)
`define DCI_DLY_RST 16'h0014
`define DCI_DLY_MAX 16'h07D0
`define DCI_FREQ_RST 16'h1770
`define DCI_FREQ_MAX 16'h9C40
`define DCI_MAP_RST 16'h0001
`define DCI_PROF_RST 16'h0001
`define DCI_NODE_MAX 16'h007F
`define DCI_RATE_MAX 16'h0005

// reply delay step of 0.1 ms expressed in clock cycles
`define DCI_CLK_NS 25
`define DCI_TICK_NS 100000
`define DCI_TICK_CYC (`DCI_TICK_NS / `DCI_CLK_NS)

`endif

//--- src/dci_pkg.sv
// types shared by the drive communication slave files.
// assumes nothing beyond a SystemVerilog-2012 tool.
package dci_pkg;
  typedef enum logic [1:0] {DCI_IDLE, DCI_WAIT} dci_state_t;
  typedef logic [15:0] dci_word_t;
  typedef logic [7:0] dci_code_t;
endpackage

//--- src/dci_slot_bank.sv
// sixteen block-transfer slots, written one word at a time.
// assumes the caller decodes the slot index and range-checks nothing.
`timescale 1ns/1ps
`default_nettype none

module dci_slot_bank #(
  parameter int SLOTS = 16,
  parameter int IW = 4
) (
  input wire logic mclk_in, // core clock
  input wire logic rst_in, // sync reset, active high
  input wire logic wr_en_in, // write strobe
  input wire logic [IW-1:0] idx_in, // slot index
  input wire dci_pkg::dci_word_t wdata_in, // write data
  output dci_pkg::dci_word_t rdata_out // slot contents at idx_in
);
  dci_pkg::dci_word_t mem_r [SLOTS];

  // slots clear to zero; values span the full word
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      for (int i = 0; i < SLOTS; i++) begin
        mem_r[i] <= 16'h0000;
      end
    end else if (wr_en_in) begin
      mem_r[idx_in] <= wdata_in;
    end
  end

  // read is plain; the top registers the reply word
  assign rdata_out = mem_r[idx_in];
endmodule

`default_nettype wire

//--- src/dci_top.sv
// drive communication slave: request decode, register file, exception
// replies, reply delay, control windows and CAN node settings.
// assumes one request at a time, held while req_ready_out is low.
`timescale 1ns/1ps
`default_nettype none
`include "dci_cfg.svh"

// Operation
// - six multi-function inputs read back in bits 0 to 5 of input status
// - output force bits 0 to 3 turn the four outputs on
// - failed request answers with function code bit 7 set
// - exception code 1 function, 2 address, 3 data, 4 not executed
// - reply held off by settable 0.0 to 200.0 ms delay, default 2.0
// - serial frequency kept across power loss, range 0 to 400 Hz; only 090Ah writes are range-checked, window frequency writes are not
// - serial frequency command change updates stored main frequency
// - sixteen block slots, 0 to 65535, default 0, read with 03H
// - map select 0 gives window 2000h, 1 gives window 6000h
// - CAN control index 2020h for method one, 2060h for two
// - keypad and terminal commands act regardless of decoding method
// - CAN warning record bits 0,1,3,4,5,6 set by their events
// - CAN profile select: 0 vendor mapping, 1 standard profile
// - CAN state reads 0 to 5 from node reset to stopped
module dci_top #(
  parameter int TICK_CYC = `DCI_TICK_CYC
) (
  input wire logic mclk_in, // core clock, 40 MHz
  input wire logic rst_in, // sync reset, active high
  input wire logic req_valid_in, // request present
  input wire logic [7:0] req_func_in, // function code
  input wire logic [15:0] req_addr_in, // register address
  input wire logic [15:0] req_data_in, // write data
  output logic req_ready_out, // request can be taken
  output logic rsp_valid_out, // reply pulse
  output logic [7:0] rsp_func_out, // echoed or error function code
  output logic [7:0] rsp_exc_out, // exception code, 0 when fine
  output logic [15:0] rsp_data_out, // read data
  input wire logic multi_input_one, // input one active
  input wire logic multi_input_two, // input two active
  input wire logic multi_input_three, // input three active
  input wire logic multi_input_four, // input four active
  input wire logic multi_input_five, // input five active
  input wire logic multi_input_six, // input six active
  output logic multi_output_one, // output one on
  output logic multi_output_two, // output two on
  output logic multi_output_three, // output three on
  output logic multi_output_four, // output four on
  input wire logic freq_src_serial_in, // serial is frequency source
  input wire logic nv_valid_in, // retained frequency is valid
  input wire logic [15:0] nv_freq_in, // retained frequency word
  output logic nv_store_out, // store pulse for retained frequency
  output logic [15:0] freq_cmd_out, // frequency command in 0.01 Hz
  input wire logic [1:0] run_src_in, // 0 keypad, 1 terminal, 2 serial
  input wire logic [1:0] keypad_cmd_in, // keypad run command
  input wire logic [1:0] term_cmd_in, // terminal run command
  output logic [1:0] run_cmd_out, // run command in force
  input wire logic [6:0] can_evt_in, // CAN warning event pulses
  input wire logic [2:0] can_state_in, // CAN node state 0 to 5
  output logic [15:0] can_ctrl_index_out, // CAN control object index
  output logic [7:0] can_ctrl_sub_out, // first CAN control subindex
  output logic can_profile_out, // 1 standard profile
  output logic [6:0] can_node_id_out, // CAN node address
  output logic [2:0] can_rate_out // CAN bit rate select
);
  dci_pkg::dci_state_t state_r;
  dci_pkg::dci_word_t dly_r, freq_r, map_r, node_r, rate_r, warn_r, prof_r;
  dci_pkg::dci_word_t ctl_cmd_r, ticks_r, slot_rd, rd_word, rin_word;
  logic [15:0] sub_r;
  logic [3:0] rout_r;
  logic [7:0] rsp_func_r, rsp_exc_r;
  logic [15:0] rsp_data_r;
  logic rsp_valid_r, nv_store_r, load_pend_r;
  logic [1:0] run_r;

  // limit check for a write; used only by the exception decode, not by the checks
  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] d);
    logic ok;
    ok = 1'b1;
    if (a == `DCI_DLY_ADDR) ok = (d <= `DCI_DLY_MAX);
    if (a == `DCI_FREQ_ADDR) ok = (d <= `DCI_FREQ_MAX);
    if (a == `DCI_MAP_ADDR || a == `DCI_PROF_ADDR) ok = (d <= 16'h0001);
    if (a == `DCI_NODE_ADDR) ok = (d <= `DCI_NODE_MAX);
    if (a == `DCI_RATE_ADDR) ok = (d <= `DCI_RATE_MAX);
    return ok;
  endfunction

  // request decode
  wire take = req_valid_in && (state_r == dci_pkg::DCI_IDLE);
  wire is_rd = (req_func_in == `DCI_FN_READ);
  wire is_wr = (req_func_in == `DCI_FN_WRITE);
  wire [15:0] win_base = map_r[0] ? `DCI_WIN_PROFILE : `DCI_WIN_LEGACY;
  wire in_win = (req_addr_in[15:8] == win_base[15:8]);
  wire win_cmd = in_win && (req_addr_in[7:0] == `DCI_WIN_CMD);
  wire win_freq = in_win && (req_addr_in[7:0] == `DCI_WIN_FREQ);
  wire [15:0] slot_off = req_addr_in - `DCI_SLOT_BASE;
  wire hit_slot = (slot_off[15:4] == 12'h000);
  wire hit_rin = (req_addr_in == `DCI_RIN_ADDR);
  wire hit_rout = (req_addr_in == `DCI_ROUT_ADDR);
  wire hit_dly = (req_addr_in == `DCI_DLY_ADDR);
  wire hit_freq = (req_addr_in == `DCI_FREQ_ADDR);
  wire hit_map = (req_addr_in == `DCI_MAP_ADDR);
  wire hit_node = (req_addr_in == `DCI_NODE_ADDR);
  wire hit_rate = (req_addr_in == `DCI_RATE_ADDR);
  wire hit_warn = (req_addr_in == `DCI_WARN_ADDR);
  wire hit_prof = (req_addr_in == `DCI_PROF_ADDR);
  wire hit_state = (req_addr_in == `DCI_STATE_ADDR);
  wire known = hit_slot | hit_rin | hit_rout | hit_dly | hit_freq |
               hit_map | hit_node | hit_rate | hit_warn | hit_prof |
               hit_state | win_cmd | win_freq;
  wire read_only = hit_rin | hit_warn | hit_state;

  // exception priority: function, address, execution, data
  wire [7:0] exc_nxt = !(is_rd || is_wr) ? `DCI_EXC_FUNC :
                       !known ? `DCI_EXC_ADDR :
                       (is_wr && read_only) ? `DCI_EXC_EXEC :
                       (is_wr && !in_range(req_addr_in, req_data_in)) ?
                       `DCI_EXC_DATA : `DCI_EXC_NONE;
  wire wr_ok = take && is_wr && (exc_nxt == `DCI_EXC_NONE);

  // window frequency write changes the retained value only on a new value
  wire freq_change = wr_ok && win_freq && freq_src_serial_in &&
                     (req_data_in != freq_r);

  // read word selection
  assign rin_word = {10'h000, multi_input_six, multi_input_five,
                     multi_input_four, multi_input_three, multi_input_two,
                     multi_input_one};
  assign rd_word = hit_rin ? rin_word :
                   hit_rout ? {12'h000, rout_r} :
                   hit_dly ? dly_r :
                   hit_freq ? freq_r :
                   hit_map ? map_r :
                   hit_node ? node_r :
                   hit_rate ? rate_r :
                   hit_warn ? warn_r :
                   hit_prof ? prof_r :
                   hit_state ? {13'h0000, can_state_in} :
                   win_cmd ? ctl_cmd_r :
                   win_freq ? freq_r :
                   hit_slot ? slot_rd : 16'h0000;

  dci_slot_bank #(.SLOTS(16), .IW(4)) u_slots (
    .mclk_in(mclk_in),
    .rst_in(rst_in),
    .wr_en_in(wr_ok && hit_slot),
    .idx_in(slot_off[3:0]),
    .wdata_in(req_data_in),
    .rdata_out(slot_rd)
  );

  // request sequencer: take, wait out the delay, then one reply pulse
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= dci_pkg::DCI_IDLE;
      ticks_r <= 16'h0000;
      sub_r <= 16'h0000;
      rsp_valid_r <= 1'b0;
    end else begin
      rsp_valid_r <= 1'b0;
      unique case (state_r)
        dci_pkg::DCI_IDLE: begin
          if (take) begin
            state_r <= dci_pkg::DCI_WAIT;
            ticks_r <= dly_r;
            sub_r <= 16'h0000;
          end
        end
        dci_pkg::DCI_WAIT: begin
          if (ticks_r == 16'h0000) begin
            rsp_valid_r <= 1'b1;
            state_r <= dci_pkg::DCI_IDLE;
          end else if (sub_r == 16'(TICK_CYC - 1)) begin
            sub_r <= 16'h0000;
            ticks_r <= ticks_r - 16'h0001;
          end else begin
            sub_r <= sub_r + 16'h0001;
          end
        end
      endcase
    end
  end

  // reply words are latched when the request is taken
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rsp_func_r <= 8'h00;
      rsp_exc_r <= 8'h00;
      rsp_data_r <= 16'h0000;
    end else if (take) begin
      rsp_exc_r <= exc_nxt;
      rsp_func_r <= (exc_nxt != `DCI_EXC_NONE) ?
                    (req_func_in | `DCI_FN_ERR) : req_func_in;
      rsp_data_r <= (exc_nxt == `DCI_EXC_NONE && is_rd) ? rd_word :
                    16'h0000;
    end
  end

  // writable settings; a failed write leaves every setting alone
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      rout_r <= 4'h0;
      dly_r <= `DCI_DLY_RST;
      map_r <= `DCI_MAP_RST;
      node_r <= 16'h0000;
      rate_r <= 16'h0000;
      prof_r <= `DCI_PROF_RST;
      ctl_cmd_r <= 16'h0000;
    end else if (wr_ok) begin
      if (hit_rout) rout_r <= req_data_in[3:0];
      if (hit_dly) dly_r <= req_data_in;
      if (hit_map) map_r <= req_data_in;
      if (hit_node) node_r <= req_data_in;
      if (hit_rate) rate_r <= req_data_in;
      if (hit_prof) prof_r <= req_data_in;
      if (win_cmd) ctl_cmd_r <= req_data_in;
    end
  end

  // retained frequency: preset, reload after reset, follow serial changes
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      freq_r <= `DCI_FREQ_RST;
      load_pend_r <= 1'b1;
      nv_store_r <= 1'b0;
    end else begin
      load_pend_r <= 1'b0;
      nv_store_r <= 1'b0;
      if (load_pend_r && nv_valid_in) begin
        freq_r <= nv_freq_in;
      end else if (freq_change) begin
        freq_r <= req_data_in;
        nv_store_r <= 1'b1;
      end else if (wr_ok && hit_freq) begin
        freq_r <= req_data_in;
        nv_store_r <= 1'b1;
      end
    end
  end

  // warning record is sticky until reset; events only ever set bits
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      warn_r <= 16'h0000;
    end else begin
      warn_r <= warn_r | ({9'h000, can_evt_in} & `DCI_WARN_MASK);
    end
  end

  // run command source: keypad and terminals ignore the decoding method
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      run_r <= 2'b00;
    end else begin
      unique case (run_src_in)
        2'd0: run_r <= keypad_cmd_in;
        2'd1: run_r <= term_cmd_in;
        2'd2: run_r <= ctl_cmd_r[1:0];
        default: run_r <= 2'b00;
      endcase
    end
  end

  // outputs
  assign req_ready_out = (state_r == dci_pkg::DCI_IDLE);
  assign rsp_valid_out = rsp_valid_r;
  assign rsp_func_out = rsp_func_r;
  assign rsp_exc_out = rsp_exc_r;
  assign rsp_data_out = rsp_data_r;
  assign multi_output_one = rout_r[0];
  assign multi_output_two = rout_r[1];
  assign multi_output_three = rout_r[2];
  assign multi_output_four = rout_r[3];
  assign nv_store_out = nv_store_r;
  assign freq_cmd_out = freq_r;
  assign run_cmd_out = run_r;
  // CAN index follows the same decoding method as the serial window
  assign can_ctrl_index_out = map_r[0] ? `DCI_CAN_IDX_M2 :
                              `DCI_CAN_IDX_M1;
  assign can_ctrl_sub_out = `DCI_CAN_SUB_FIRST;
  assign can_profile_out = prof_r[0];
  assign can_node_id_out = node_r[6:0];
  assign can_rate_out = rate_r[2:0];

  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  a_rin_read: assert property (
    take && is_rd && hit_rin |=> rsp_data_r == $past(rin_word))
    else $error("input status read mismatch");
  a_rout_force: assert property (
    wr_ok && hit_rout |=> multi_output_one == $past(req_data_in[0]) &&
      multi_output_four == $past(req_data_in[3]))
    else $error("output force not applied");
  a_err_bit: assert property (
    rsp_valid_out && rsp_exc_out != 8'h00 |-> rsp_func_out[7])
    else $error("error reply lacks bit 7");
  a_exc_func: assert property (
    take && !is_rd && !is_wr |=> rsp_exc_r == 8'h01)
    else $error("unsupported function not code 1");
  a_exc_addr: assert property (
    take && (is_rd || is_wr) && map_r[0] && req_addr_in == 16'h2000 |=>
      rsp_exc_r == 8'h02)
    else $error("closed window not refused");
  a_delay_zero: assert property (
    take && dly_r == 16'h0000 |-> ##1 !rsp_valid_out ##1 rsp_valid_out)
    else $error("zero delay reply not two cycles");
  a_delay_hold: assert property (
    take && dly_r != 16'h0000 |-> ##1 !rsp_valid_out [*5])
    else $error("reply came before delay");
  a_freq_follow: assert property (
    freq_change && !load_pend_r |=> freq_r == $past(req_data_in) &&
      nv_store_out)
    else $error("serial frequency not retained");
  a_warn_sticky: assert property (
    (warn_r & $past(warn_r)) == $past(warn_r))
    else $error("warning bit lost");
  a_state_read: assert property (
    take && is_rd && hit_state |=> rsp_data_r[2:0] == $past(can_state_in))
    else $error("CAN state read mismatch");

  c_read_ok: cover property (take && is_rd && exc_nxt == 8'h00);
  c_error: cover property (rsp_valid_out && rsp_exc_out == 8'h03);
  c_slot_wr: cover property (wr_ok && hit_slot ##[1:40] rsp_valid_out);
  c_map_flip: cover property (wr_ok && hit_map && req_data_in == 16'h0000);
endmodule

`default_nettype wire

//--- dv/dci_host_model.sv
// host-side partner: issues one request at a time and collects the reply.
// assumes one core clock and a slave that holds ready low while busy.
`timescale 1ns/1ps
`default_nettype none

module dci_host_model (
  input wire logic mclk_in, // core clock
  input wire logic ready_in, // slave can take a request
  input wire logic rsp_valid_in, // reply pulse
  input wire logic [7:0] rsp_func_in, // reply function code
  input wire logic [7:0] rsp_exc_in, // reply exception code
  input wire logic [15:0] rsp_data_in, // reply data
  output logic valid_out, // request present
  output logic [7:0] func_out, // function code
  output logic [15:0] addr_out, // register address
  output logic [15:0] data_out // write data
);
  int idle_cyc = 0; // idle edges before a request, 0 gives back-to-back

  // quiet bus at time zero
  initial begin
    valid_out = 1'h0;
    func_out = 8'h00;
    addr_out = 16'h0000;
    data_out = 16'h0000;
  end

  // request held until the take edge; released lines carry the inverse so
  // a stale address or data word cannot pass for a fresh one
  task automatic xfer(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] d, output logic [7:0] rf, output logic [7:0] rx,
    output logic [15:0] rd, output int lat);
    int i;
    lat = -1;
    repeat (idle_cyc + 1) @(posedge mclk_in);
    valid_out <= 1'h1;
    func_out <= f;
    addr_out <= a;
    data_out <= d;
    i = 0;
    do begin
      @(posedge mclk_in);
      i++;
    end while (ready_in !== 1'h1 && i < 64);
    // the edge that saw ready high took the request; release only now
    valid_out <= 1'h0;
    func_out <= ~f;
    addr_out <= ~a;
    data_out <= ~d;
    // latency counted in edges after the take edge; reply words are
    // taken at the same edge that samples the pulse high
    for (i = 1; i <= 20000; i++) begin
      @(posedge mclk_in);
      if (rsp_valid_in === 1'h1) begin
        lat = i;
        break;
      end
    end
    rf = rsp_func_in;
    rx = rsp_exc_in;
    rd = rsp_data_in;
  endtask
endmodule

`default_nettype wire

//--- dv/tb_top.sv
// self-checking bench for the drive communication slave.
// assumes the reply delay tick shortened to 4 clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "dci_cfg.svh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

module tb_top;
  localparam int TICK = 4;
  logic clk, rst, vld, rdy, rv, fsrc, nvv, nvs, prof;
  logic [7:0] fn, rf, rx, rfo, rxo, sub;
  logic [15:0] ad, wd, rd, rdo, nvf, fcmd, cidx, v;
  logic [15:0] slot [16];
  logic [5:0] mi;
  logic [3:0] mo;
  logic [1:0] rsrc, kcmd, tcmd, rcmd;
  logic [6:0] evt, node;
  logic [2:0] cst, rate;
  int failures, n_checks, seed, lat, stores, i, s0;

  dci_top #(.TICK_CYC(TICK)) DUT (.mclk_in(clk), .rst_in(rst),
    .req_valid_in(vld), .req_func_in(fn), .req_addr_in(ad), .req_data_in(wd),
    .req_ready_out(rdy), .rsp_valid_out(rv), .rsp_func_out(rfo),
    .rsp_exc_out(rxo), .rsp_data_out(rdo), .multi_input_one(mi[0]),
    .multi_input_two(mi[1]), .multi_input_three(mi[2]),
    .multi_input_four(mi[3]), .multi_input_five(mi[4]),
    .multi_input_six(mi[5]), .multi_output_one(mo[0]),
    .multi_output_two(mo[1]), .multi_output_three(mo[2]),
    .multi_output_four(mo[3]), .freq_src_serial_in(fsrc),
    .nv_valid_in(nvv), .nv_freq_in(nvf), .nv_store_out(nvs),
    .freq_cmd_out(fcmd), .run_src_in(rsrc), .keypad_cmd_in(kcmd),
    .term_cmd_in(tcmd), .run_cmd_out(rcmd), .can_evt_in(evt),
    .can_state_in(cst), .can_ctrl_index_out(cidx), .can_ctrl_sub_out(sub),
    .can_profile_out(prof), .can_node_id_out(node), .can_rate_out(rate));
  dci_host_model host (.mclk_in(clk), .ready_in(rdy), .rsp_valid_in(rv),
    .rsp_func_in(rfo), .rsp_exc_in(rxo), .rsp_data_in(rdo), .valid_out(vld),
    .func_out(fn), .addr_out(ad), .data_out(wd));

  // 40 MHz clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end

  // count store pulses of the retained frequency
  always @(posedge clk) begin
    if (nvs === 1'h1) stores++;
  end

  // expectations worked out from the documented behaviour
  function automatic logic [7:0] exp_err(input logic [7:0] f);
    return f | 8'h80;
  endfunction
  function automatic int exp_lat(input int d);
    return 2 + d * TICK;
  endfunction
  function automatic logic [15:0] exp_win(input logic m);
    return m ? 16'h6000 : 16'h2000;
  endfunction
  function automatic logic [15:0] exp_idx(input logic m);
    return m ? 16'h2060 : 16'h2020;
  endfunction
  function automatic logic [15:0] exp_warn(input int b);
    return (b == 2) ? 16'h0000 : 16'(1 << b);
  endfunction

  task automatic end_sim();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one access with its full reply checked; a lost reply ends the run
  task automatic acc(input logic [7:0] f, input logic [15:0] a,
    input logic [15:0] d, input logic [7:0] ex, input logic [15:0] ed);
    host.xfer(f, a, d, rf, rx, rd, lat);
    if (lat < 0) begin
      failures++;
      $display("[ERR] %0t no reply", $time);
      end_sim();
    end
    `CHK(rf, (ex == 8'h00) ? f : exp_err(f))
    `CHK(rx, ex)
    `CHK(rd, ed)
  endtask

  // registered outputs need two edges after the cause
  task automatic settle();
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask

  initial begin
    seed = 26647;
    failures = 0;
    n_checks = 0;
    stores = 0;
    rst = 1'h1;
    {mi, fsrc, nvv, nvf, rsrc, kcmd, tcmd, evt, cst} = '0;
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    // reset values and default reply delay
    acc(8'h03, `DCI_DLY_ADDR, 16'h0000, 8'h00, 16'h0014);
    `CHK(lat, exp_lat(20))
    acc(8'h03, `DCI_FREQ_ADDR, 16'h0000, 8'h00, 16'h1770);
    acc(8'h03, `DCI_MAP_ADDR, 16'h0000, 8'h00, 16'h0001);
    acc(8'h03, `DCI_PROF_ADDR, 16'h0000, 8'h00, 16'h0001);
    acc(8'h03, `DCI_SLOT_BASE, 16'h0000, 8'h00, 16'h0000);
    `CHK(prof, 1'h1)
    $display("done: reset values");
    // delay at a middle value, the maximum, one past it, then zero
    acc(8'h06, `DCI_DLY_ADDR, 16'h0003, 8'h00, 16'h0000);
    acc(8'h03, `DCI_DLY_ADDR, 16'h0000, 8'h00, 16'h0003);
    `CHK(lat, exp_lat(3))
    acc(8'h06, `DCI_DLY_ADDR, 16'h07D0, 8'h00, 16'h0000);
    acc(8'h06, `DCI_DLY_ADDR, 16'h07D1, 8'h03, 16'h0000);
    acc(8'h06, `DCI_DLY_ADDR, 16'h0000, 8'h00, 16'h0000);
    acc(8'h03, `DCI_DLY_ADDR, 16'h0000, 8'h00, 16'h0000);
    `CHK(lat, exp_lat(0))
    $display("done: reply delay");
    // remote inputs and forced outputs, varied request spacing
    for (i = 0; i < 8; i++) begin
      v = $random(seed);
      host.idle_cyc = i % 3;
      @(posedge clk);
      mi <= v[5:0];
      acc(8'h03, `DCI_RIN_ADDR, 16'h0000, 8'h00, {10'h000, v[5:0]});
      acc(8'h06, `DCI_ROUT_ADDR, {12'h000, v[9:6]}, 8'h00, 16'h0000);
      settle();
      `CHK(mo, v[9:6])
    end
    // error replies leave the frequency register unchanged
    acc(8'h10, 16'h1234, 16'h0000, 8'h01, 16'h0000);
    acc(8'h06, 16'h1234, 16'h0001, 8'h02, 16'h0000);
    acc(8'h06, `DCI_RIN_ADDR, 16'h0001, 8'h04, 16'h0000);
    acc(8'h06, `DCI_WARN_ADDR, 16'h0001, 8'h04, 16'h0000);
    acc(8'h06, `DCI_FREQ_ADDR, 16'h9C41, 8'h03, 16'h0000);
    acc(8'h03, `DCI_FREQ_ADDR, 16'h0000, 8'h00, 16'h1770);
    $display("done: io and errors");
    // all sixteen slots, the boundary value FFFF in slot 0 first
    for (i = 0; i < 16; i++) begin
      slot[i] = (i == 0) ? 16'hFFFF : 16'($random(seed));
      acc(8'h06, `DCI_SLOT_BASE + 16'(i), slot[i], 8'h00, 16'h0000);
    end
    for (i = 0; i < 16; i++) begin
      acc(8'h03, `DCI_SLOT_BASE + 16'(i), 16'h0000, 8'h00, slot[i]);
    end
    $display("done: block slots");
    // both map settings: own window works, the other refuses
    for (i = 0; i < 2; i++) begin
      v = $random(seed);
      @(posedge clk);
      rsrc <= 2'h2;
      kcmd <= v[3:2];
      tcmd <= v[5:4];
      acc(8'h06, `DCI_MAP_ADDR, 16'(i), 8'h00, 16'h0000);
      acc(8'h06, exp_win(i[0]), {14'h0000, v[1:0]}, 8'h00, 16'h0000);
      acc(8'h06, exp_win(!i[0]), 16'h0001, 8'h02, 16'h0000);
      acc(8'h06, exp_win(i[0]) + 16'h00FF, 16'h0000, 8'h02, 16'h0000);
      settle();
      `CHK(rcmd, v[1:0])
      `CHK(cidx, exp_idx(i[0]))
      `CHK(sub, 8'h01)
      @(posedge clk);
      rsrc <= 2'h0;
      settle();
      `CHK(rcmd, v[3:2])
      @(posedge clk);
      rsrc <= 2'h1;
      settle();
      `CHK(rcmd, v[5:4])
      @(posedge clk);
      rsrc <= 2'h3;
      settle();
      `CHK(rcmd, 2'h0)
    end
    acc(8'h06, `DCI_PROF_ADDR, 16'h0000, 8'h00, 16'h0000);
    acc(8'h06, `DCI_PROF_ADDR, 16'h0002, 8'h03, 16'h0000);
    acc(8'h06, `DCI_NODE_ADDR, 16'h007F, 8'h00, 16'h0000);
    acc(8'h06, `DCI_NODE_ADDR, 16'h0080, 8'h03, 16'h0000);
    acc(8'h06, `DCI_RATE_ADDR, 16'h0005, 8'h00, 16'h0000);
    acc(8'h06, `DCI_RATE_ADDR, 16'h0006, 8'h03, 16'h0000);
    settle();
    `CHK(prof, 1'h0)
    `CHK(node, 7'h7F)
    `CHK(rate, 3'h5)
    $display("done: maps and profile");
    // warning record is sticky; bit 2 has no event
    v = 16'h0000;
    for (i = 0; i < 7; i++) begin
      @(posedge clk);
      evt <= 7'(1 << i);
      @(posedge clk);
      evt <= 7'h00;
      v = v | exp_warn(i);
      acc(8'h03, `DCI_WARN_ADDR, 16'h0000, 8'h00, v);
    end
    for (i = 0; i < 6; i++) begin
      @(posedge clk);
      cst <= 3'(i);
      acc(8'h03, `DCI_STATE_ADDR, 16'h0000, 8'h00, 16'(i));
    end
    $display("done: can status");
    // serial frequency: store on change only, then a power cycle
    // kept off the preset so the first write is always a change
    v = 16'($unsigned($random(seed)) % 34000) + 16'h1771;
    @(posedge clk);
    fsrc <= 1'h1;
    s0 = stores;
    acc(8'h06, exp_win(1'h1) + 16'h0001, v, 8'h00, 16'h0000);
    acc(8'h06, exp_win(1'h1) + 16'h0001, v, 8'h00, 16'h0000);
    settle();
    `CHK(fcmd, v)
    `CHK(stores, s0 + 1)
    acc(8'h03, `DCI_FREQ_ADDR, 16'h0000, 8'h00, v);
    @(posedge clk);
    rst <= 1'h1;
    nvv <= 1'h1;
    nvf <= 16'h2710;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    settle();
    `CHK(fcmd, 16'h2710)
    acc(8'h03, `DCI_FREQ_ADDR, 16'h0000, 8'h00, 16'h2710);
    $display("done: retained frequency");
    end_sim();
  end
endmodule

`default_nettype wire
